// >>> judge_pkg.sv
// constants, types and register map of the weight comparator judgement block
package judge_pkg;
	localparam int VAL_W  = 18;
	localparam int WIDE_W = 21;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NOUT   = 5;
	localparam int NBATCH = 6;

	typedef logic signed [VAL_W-1:0]  val_t;
	typedef logic signed [WIDE_W-1:0] wide_t;

	// ==========================================
	// register byte addresses
	localparam logic [ADDR_W-1:0] ADDR_CTRL      = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_DIRECTION = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_TARGET    = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_CMP_BASE  = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_BATCH_BASE = 8'h20;
	localparam logic [ADDR_W-1:0] ADDR_STATUS    = 8'h38;
	localparam logic [ADDR_W-1:0] ADDR_STEP      = 8'h04;

	// ==========================================
	// control field layout
	localparam int CTRL_MODE_LSB  = 0;
	localparam int CTRL_MODE_W    = 4;
	localparam int CTRL_OFFD_BIT  = 4;
	localparam int CTRL_WIDTH_LSB = 8;
	localparam int CTRL_WIDTH_W   = 7;
	localparam int CODE_W         = 2;

	// ==========================================
	// reset values and limits
	localparam logic [CTRL_MODE_W-1:0]  MODE_RST   = 4'h4;
	localparam logic [CTRL_MODE_W-1:0]  MODE_OFF   = 4'h0;
	localparam logic [CTRL_MODE_W-1:0]  MODE_IN    = 4'h7;
	localparam logic [CTRL_MODE_W-1:0]  MODE_OUT   = 4'h8;
	localparam logic [CTRL_WIDTH_W-1:0] WIDTH_RST  = 7'h00;
	localparam logic [CTRL_WIDTH_W-1:0] WIDTH_MAX  = 7'h63;
	localparam logic [CODE_W*NOUT-1:0]  CODES_RST  = 10'h000;
	localparam logic signed [DATA_W-1:0] SET_MAX   = 32'sh0001869F;
	localparam logic signed [DATA_W-1:0] SET_MIN   = -32'sh0001869F;
	localparam wide_t                   FIVE_D     = 21'sh000005;

	// direction codes, target codes
	localparam logic [CODE_W-1:0] DIR_OVER  = 2'h1;
	localparam logic [CODE_W-1:0] DIR_LESS  = 2'h2;
	localparam logic [CODE_W-1:0] TSEL_GROSS = 2'h1;
	localparam logic [CODE_W-1:0] TSEL_NET   = 2'h2;

	// batch set value order
	localparam int B_TARGET = 0;
	localparam int B_FALL   = 1;
	localparam int B_PRESET = 2;
	localparam int B_NZERO  = 3;
	localparam int B_OVER   = 4;
	localparam int B_UNDER  = 5;

	typedef enum logic [1:0] {
		CMP_GE = 2'b00,
		CMP_LE = 2'b01,
		CMP_GT = 2'b10,
		CMP_LT = 2'b11
	} cmp_e;
endpackage : judge_pkg

// >>> weight_comparator_judgement.sv
// comparator judgement logic with apb register file
`timescale 1ns/1ps

module weight_comparator_judgement (
	input  wire logic                          mclk,
	input  wire logic                          rst,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [judge_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [judge_pkg::DATA_W-1:0]  pwdata,
	output logic      [judge_pkg::DATA_W-1:0]  prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic                          disp_update,
	input  wire logic                          display_is_net,
	input  wire logic                          weight_stable,
	input  wire judge_pkg::val_t               gross_value,
	input  wire judge_pkg::val_t               net_value,
	output logic                               first_judgement_output,
	output logic                               second_judgement_output,
	output logic                               third_judgement_output,
	output logic                               fourth_judgement_output,
	output logic                               fifth_judgement_output
);
	import judge_pkg::*;

	typedef struct packed {
		logic [CTRL_MODE_W-1:0]  mode;
		logic                    off_delay;
		logic [CTRL_WIDTH_W-1:0] width;
		logic [CODE_W*NOUT-1:0]  dir;
		logic [CODE_W*NOUT-1:0]  tsel;
		val_t [NOUT-1:0]         cset;
		val_t [NBATCH-1:0]       bset;
		logic [NOUT-1:0]         judge;
		logic                    pready;
		logic                    pslverr;
		logic [DATA_W-1:0]       prdata;
	} state_s;

	state_s state_r;
	state_s state_nxt;

	// ==========================================
	// helpers
	function automatic wide_t wx(input val_t v);
		wx = wide_t'(v);
	endfunction : wx

	function automatic logic cmp(input wide_t v, input wide_t t, input cmp_e k);
		case (k)
			CMP_GE: cmp = (v >= t);
			CMP_LE: cmp = (v <= t);
			CMP_GT: cmp = (v > t);
			CMP_LT: cmp = (v < t);
			default: cmp = 1'b0;
		endcase
	endfunction : cmp

	// threshold shifted by the width in the direction that makes k harder
	function automatic wide_t shift(input wide_t t, input cmp_e k, input wide_t w);
		if (k == CMP_GE || k == CMP_GT) begin
			shift = t + w;
		end else begin
			shift = t - w;
		end
	endfunction : shift

	function automatic logic hyst(input wide_t v, input wide_t t, input cmp_e k,
			input wide_t w, input logic cur, input logic offd);
		logic plain;
		logic hard;
		logic easy;
		plain = cmp(v, t, k);
		hard  = cmp(v, shift(t, k, w), k);
		easy  = cmp(v, shift(t, k, -w), k);
		if (offd) begin
			hyst = cur ? easy : plain;
		end else begin
			hyst = cur ? plain : hard;
		end
	endfunction : hyst

	function automatic logic in_range(input logic [DATA_W-1:0] d);
		in_range = ($signed(d) <= SET_MAX) && ($signed(d) >= SET_MIN);
	endfunction : in_range

	// ==========================================
	// combinational values
	wide_t           disp_v;
	wide_t           gross_w;
	wide_t           net_w;
	wide_t           hw;
	wide_t           thr_fall;
	wide_t           thr_pre;
	wide_t           thr_over;
	wide_t           thr_under;
	wide_t           sel_v   [NOUT];
	logic [NOUT-1:0] simple_j;
	logic [NOUT-1:0] batch_j;
	logic            qual_ok;
	logic            batch_mode;
	logic [CODE_W-1:0] d2;
	logic [CODE_W-1:0] d3;

	always_comb begin
		disp_v    = display_is_net ? wx(net_value) : wx(gross_value);
		gross_w   = wx(gross_value);
		net_w     = wx(net_value);
		hw        = wide_t'(state_r.width);
		thr_fall  = wx(state_r.bset[B_TARGET]) - wx(state_r.bset[B_FALL]);
		thr_pre   = wx(state_r.bset[B_TARGET]) - wx(state_r.bset[B_PRESET]);
		thr_over  = wx(state_r.bset[B_TARGET]) - wx(state_r.bset[B_OVER]);
		thr_under = wx(state_r.bset[B_TARGET]) - wx(state_r.bset[B_UNDER]);
		batch_mode = (state_r.mode == MODE_IN) || (state_r.mode == MODE_OUT);
		d2 = state_r.dir[CODE_W*1 +: CODE_W];
		d3 = state_r.dir[CODE_W*2 +: CODE_W];
		// per-output compared value
		for (int i = 0; i < NOUT; i++) begin
			case (state_r.tsel[CODE_W*i +: CODE_W])
				TSEL_GROSS: sel_v[i] = gross_w;
				TSEL_NET:   sel_v[i] = net_w;
				default:    sel_v[i] = disp_v;
			endcase
		end
		// simple comparison per direction code
		for (int i = 0; i < NOUT; i++) begin
			case (state_r.dir[CODE_W*i +: CODE_W])
				DIR_OVER: simple_j[i] = hyst(sel_v[i], wx(state_r.cset[i]), CMP_GE, hw,
					state_r.judge[i], state_r.off_delay);
				DIR_LESS: simple_j[i] = hyst(sel_v[i], wx(state_r.cset[i]), CMP_LE, hw,
					state_r.judge[i], state_r.off_delay);
				default:  simple_j[i] = 1'b0;
			endcase
		end
		if (d2 == DIR_OVER && d3 == DIR_OVER) begin
			simple_j[0] = hyst(sel_v[0], wx(state_r.cset[1]), CMP_LT, hw, state_r.judge[0],
					state_r.off_delay)
				&& hyst(sel_v[0], wx(state_r.cset[2]), CMP_LT, hw, state_r.judge[0],
					state_r.off_delay);
		end else if (d2 == DIR_LESS && d3 == DIR_LESS) begin
			simple_j[0] = hyst(sel_v[0], wx(state_r.cset[1]), CMP_GT, hw, state_r.judge[0],
					state_r.off_delay)
				&& hyst(sel_v[0], wx(state_r.cset[2]), CMP_LT, hw, state_r.judge[0],
					state_r.off_delay);
		end
		// stability and near-zero qualifiers of modes 1 to 6
		case (state_r.mode)
			4'h1:    qual_ok = 1'b1;
			4'h2:    qual_ok = weight_stable;
			4'h3:    qual_ok = (disp_v > FIVE_D);
			4'h4:    qual_ok = weight_stable && (disp_v > FIVE_D);
			4'h5:    qual_ok = (disp_v > FIVE_D) || (disp_v < -FIVE_D);
			4'h6:    qual_ok = weight_stable && ((disp_v > FIVE_D) || (disp_v < -FIVE_D));
			default: qual_ok = 1'b0;
		endcase
		// batching
		batch_j[2] = hyst(gross_w, wx(state_r.bset[B_NZERO]), CMP_LE, hw, state_r.judge[2],
			state_r.off_delay);
		if (state_r.mode == MODE_IN) begin
			batch_j[0] = hyst(net_w, thr_fall, CMP_GE, hw, state_r.judge[0],
				state_r.off_delay);
			batch_j[1] = hyst(net_w, thr_pre, CMP_GE, hw, state_r.judge[1],
				state_r.off_delay);
			batch_j[3] = hyst(net_w, thr_over, CMP_GT, hw, state_r.judge[3],
				state_r.off_delay);
			batch_j[4] = hyst(net_w, thr_under, CMP_LT, hw, state_r.judge[4],
				state_r.off_delay);
		end else begin
			batch_j[0] = hyst(net_w, -thr_fall, CMP_LE, hw, state_r.judge[0],
				state_r.off_delay);
			batch_j[1] = hyst(net_w, -thr_pre, CMP_LE, hw, state_r.judge[1],
				state_r.off_delay);
			batch_j[3] = hyst(net_w, -thr_fall, CMP_LT, hw, state_r.judge[3],
				state_r.off_delay);
			batch_j[4] = hyst(net_w, -thr_fall, CMP_GT, hw, state_r.judge[4],
				state_r.off_delay);
		end
	end

	// ==========================================
	// next state
	logic [ADDR_W-1:0] cidx;
	logic [ADDR_W-1:0] bidx;
	logic              setup;
	logic              wr_take;

	always_comb begin
		state_nxt = state_r;
		cidx    = (paddr - ADDR_CMP_BASE) >> 2;
		bidx    = (paddr - ADDR_BATCH_BASE) >> 2;
		setup   = psel && !penable;
		wr_take = psel && penable && state_r.pready && pwrite && !state_r.pslverr;
		// judgement, updated with the display only
		if (disp_update) begin
			if (batch_mode) begin
				state_nxt.judge = batch_j;
			end else if (qual_ok) begin
				state_nxt.judge = simple_j;
			end else begin
				state_nxt.judge = '0;
			end
		end
		// apb answer prepared in the setup cycle
		state_nxt.pready  = setup;
		state_nxt.pslverr = 1'b0;
		state_nxt.prdata  = '0;
		if (setup) begin
			if (paddr == ADDR_CTRL) begin
				state_nxt.prdata[CTRL_MODE_LSB +: CTRL_MODE_W]   = state_r.mode;
				state_nxt.prdata[CTRL_OFFD_BIT]                  = state_r.off_delay;
				state_nxt.prdata[CTRL_WIDTH_LSB +: CTRL_WIDTH_W] = state_r.width;
				state_nxt.pslverr = pwrite &&
					((pwdata[CTRL_MODE_LSB +: CTRL_MODE_W] > MODE_OUT) ||
					 (pwdata[CTRL_WIDTH_LSB +: CTRL_WIDTH_W] > WIDTH_MAX));
			end else if (paddr == ADDR_DIRECTION) begin
				state_nxt.prdata[CODE_W*NOUT-1:0] = state_r.dir;
			end else if (paddr == ADDR_TARGET) begin
				state_nxt.prdata[CODE_W*NOUT-1:0] = state_r.tsel;
			end else if (paddr >= ADDR_CMP_BASE && paddr < ADDR_BATCH_BASE && paddr[1:0] == 2'h0) begin
				state_nxt.prdata  = DATA_W'(signed'(state_r.cset[cidx]));
				state_nxt.pslverr = pwrite && !in_range(pwdata);
			end else if (paddr >= ADDR_BATCH_BASE && paddr < ADDR_STATUS && paddr[1:0] == 2'h0) begin
				state_nxt.prdata  = DATA_W'(signed'(state_r.bset[bidx]));
				state_nxt.pslverr = pwrite && !in_range(pwdata);
			end else if (paddr == ADDR_STATUS) begin
				state_nxt.prdata[NOUT-1:0] = state_r.judge;
				state_nxt.pslverr = pwrite;
			end else begin
				state_nxt.pslverr = 1'b1;
			end
		end
		// write takes effect in the access cycle
		if (wr_take) begin
			if (paddr == ADDR_CTRL) begin
				state_nxt.mode      = pwdata[CTRL_MODE_LSB +: CTRL_MODE_W];
				state_nxt.off_delay = pwdata[CTRL_OFFD_BIT];
				state_nxt.width     = pwdata[CTRL_WIDTH_LSB +: CTRL_WIDTH_W];
			end else if (paddr == ADDR_DIRECTION) begin
				state_nxt.dir = pwdata[CODE_W*NOUT-1:0];
			end else if (paddr == ADDR_TARGET) begin
				state_nxt.tsel = pwdata[CODE_W*NOUT-1:0];
			end else if (paddr < ADDR_BATCH_BASE) begin
				state_nxt.cset[cidx] = pwdata[VAL_W-1:0];
			end else begin
				state_nxt.bset[bidx] = pwdata[VAL_W-1:0];
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_r           <= '0;
			state_r.mode      <= MODE_RST;
			state_r.width     <= WIDTH_RST;
			state_r.dir       <= CODES_RST;
			state_r.tsel      <= CODES_RST;
			state_r.off_delay <= 1'b0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign prdata                  = state_r.prdata;
	assign pready                  = state_r.pready;
	assign pslverr                 = state_r.pslverr;
	assign first_judgement_output  = state_r.judge[0];
	assign second_judgement_output = state_r.judge[1];
	assign third_judgement_output  = state_r.judge[2];
	assign fourth_judgement_output = state_r.judge[3];
	assign fifth_judgement_output  = state_r.judge[4];

	// ==========================================
	// checks
	logic nohys;
	logic hit_in_first;
	logic hit_out_fourth;
	logic hit_nz;
	logic hit_over_s2;
	logic hit_in_second;
	logic hit_out_fifth;
	logic hit_less_s3;
	logic qual_fail;
	assign nohys          = (state_r.width == WIDTH_RST);
	assign hit_in_first   = (net_w >= thr_fall);
	assign hit_out_fourth = (net_w < -thr_fall);
	assign hit_nz         = (gross_w <= wx(state_r.bset[B_NZERO]));
	assign hit_over_s2    = (sel_v[1] >= wx(state_r.cset[1]));
	assign hit_in_second  = (net_w >= thr_pre);
	assign hit_out_fifth  = (net_w > -thr_fall);
	assign hit_less_s3    = (sel_v[2] <= wx(state_r.cset[2]));
	assign qual_fail      = !batch_mode && !qual_ok;

	a_judge_hold_idle: assert property (@(posedge mclk) disable iff (rst)
		!disp_update |=> $stable(state_r.judge)) else $error("judgement moved without update");
	a_mode_off_clear: assert property (@(posedge mclk) disable iff (rst)
		disp_update && state_r.mode == MODE_OFF |=> state_r.judge == '0)
		else $error("outputs on in mode off");
	a_qual_fail_clear: assert property (@(posedge mclk) disable iff (rst)
		disp_update && qual_fail |=> state_r.judge == '0)
		else $error("outputs on with qualifier failing");
	a_weighin_first: assert property (@(posedge mclk) disable iff (rst)
		disp_update && state_r.mode == MODE_IN && nohys
		|=> first_judgement_output == $past(hit_in_first)) else $error("weigh-in first wrong");
	a_weighin_second: assert property (@(posedge mclk) disable iff (rst)
		disp_update && state_r.mode == MODE_IN && nohys
		|=> second_judgement_output == $past(hit_in_second)) else $error("weigh-in second wrong");
	a_weighout_fourth: assert property (@(posedge mclk) disable iff (rst)
		disp_update && state_r.mode == MODE_OUT && nohys
		|=> fourth_judgement_output == $past(hit_out_fourth)) else $error("weigh-out fourth wrong");
	a_weighout_fifth: assert property (@(posedge mclk) disable iff (rst)
		disp_update && state_r.mode == MODE_OUT && nohys
		|=> fifth_judgement_output == $past(hit_out_fifth)) else $error("weigh-out fifth wrong");
	a_near_zero_out: assert property (@(posedge mclk) disable iff (rst)
		disp_update && batch_mode && nohys
		|=> third_judgement_output == $past(hit_nz)) else $error("near zero output wrong");
	a_over_second: assert property (@(posedge mclk) disable iff (rst)
		disp_update && state_r.mode == 4'h1 && d2 == DIR_OVER && nohys
		|=> second_judgement_output == $past(hit_over_s2)) else $error("over second wrong");
	a_under_third: assert property (@(posedge mclk) disable iff (rst)
		disp_update && state_r.mode == 4'h1 && d3 == DIR_LESS && nohys
		|=> third_judgement_output == $past(hit_less_s3)) else $error("under third wrong");
	a_width_limit: assert property (@(posedge mclk) disable iff (rst)
		state_r.width <= WIDTH_MAX) else $error("hysteresis width above limit");
	a_mode_limit: assert property (@(posedge mclk) disable iff (rst)
		state_r.mode <= MODE_OUT) else $error("mode code above limit");
	a_apb_ready_pulse: assert property (@(posedge mclk) disable iff (rst)
		psel && !penable |=> pready ##1 !pready) else $error("ready not one cycle");
endmodule : weight_comparator_judgement

// >>> relay_bank.sv
// partner model: relay coils driven by the open collector judgement outputs
`timescale 1ns/1ps

// ==========================================
// relay bank
module relay_bank (
	input  wire logic       first_judgement_output,
	input  wire logic       second_judgement_output,
	input  wire logic       third_judgement_output,
	input  wire logic       fourth_judgement_output,
	input  wire logic       fifth_judgement_output,
	output logic      [4:0] closed
);
	// coil energised while the collector sinks current
	assign closed = {fifth_judgement_output, fourth_judgement_output, third_judgement_output,
		second_judgement_output, first_judgement_output};
endmodule : relay_bank

// >>> testbench.sv
// self-checking bench of the judgement block
`timescale 1ns/1ps

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
	$display("BAD %0t got %0h expected %0h", $time, got, exp); end end

module testbench;
	import judge_pkg::*;

	// ==========================================
	// signals
	logic              mclk;
	logic              rst;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata;
	logic [DATA_W-1:0] prdata;
	logic              pready;
	logic              pslverr;
	logic              disp_update;
	logic              display_is_net;
	logic              weight_stable;
	val_t              gross_value;
	val_t              net_value;
	logic [4:0]        outs;
	logic [4:0]        closed;
	int                error_cnt;
	int                num_checks;

	weight_comparator_judgement dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .disp_update(disp_update), .display_is_net(display_is_net),
		.weight_stable(weight_stable), .gross_value(gross_value), .net_value(net_value),
		.first_judgement_output(outs[0]), .second_judgement_output(outs[1]),
		.third_judgement_output(outs[2]), .fourth_judgement_output(outs[3]),
		.fifth_judgement_output(outs[4]));

	relay_bank relays (.first_judgement_output(outs[0]), .second_judgement_output(outs[1]),
		.third_judgement_output(outs[2]), .fourth_judgement_output(outs[3]),
		.fifth_judgement_output(outs[4]), .closed(closed));

	// ==========================================
	// bus and display tasks
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		output logic [DATA_W-1:0] rd, output logic e);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic ee);
		logic [DATA_W-1:0] rd;
		logic              e;
		apb(1'b1, a, d, rd, e);
		`CHK(e, ee)
	endtask : wr

	task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x, input logic ee);
		logic [DATA_W-1:0] rd;
		logic              e;
		apb(1'b0, a, 32'h00000000, rd, e);
		`CHK(rd, x)
		`CHK(e, ee)
	endtask : rdchk

	task automatic upd(input val_t g, input val_t n, input logic [4:0] m, input logic [4:0] x);
		@(posedge mclk);
		gross_value <= g;
		net_value <= n;
		disp_update <= 1'b1;
		@(posedge mclk);
		disp_update <= 1'b0;
		@(posedge mclk);
		#1;
		`CHK(closed & m, x & m)
	endtask : upd

	// ==========================================
	// scenarios
	task automatic t_reset();
		rdchk(ADDR_CTRL, 32'h00000004, 1'b0);
		rdchk(ADDR_DIRECTION, 32'h00000000, 1'b0);
		rdchk(ADDR_TARGET, 32'h00000000, 1'b0);
		rdchk(8'h3C, 32'h00000000, 1'b1);
		wr(ADDR_STATUS, 32'h0000001F, 1'b1);
	endtask : t_reset

	task automatic t_in();
		wr(ADDR_CTRL, 32'h00000007, 1'b0);
		wr(8'h20, 32'h000003E8, 1'b0);
		wr(8'h24, 32'h0000000A, 1'b0);
		wr(8'h28, 32'h00000064, 1'b0);
		wr(8'h2C, 32'h00000005, 1'b0);
		wr(8'h30, 32'hFFFFFFFB, 1'b0);
		wr(8'h34, 32'h00000005, 1'b0);
		wr(8'h2C, 32'hFFFE7960, 1'b1);
		wr(8'h28, 32'h000186A0, 1'b1);
		rdchk(8'h30, 32'hFFFFFFFB, 1'b0);
		rdchk(8'h2C, 32'h00000005, 1'b0);
		upd(18'sd990, 18'sd990, 5'h1F, 5'b10011);
		upd(18'sd6, 18'sd989, 5'h1F, 5'b10010);
		upd(18'sd5, 18'sd1005, 5'h1F, 5'b00111);
		upd(18'sd3, 18'sd1006, 5'h1F, 5'b01111);
	endtask : t_in

	task automatic t_out();
		wr(ADDR_CTRL, 32'h00000008, 1'b0);
		upd(18'sd6, -18'sd990, 5'h1F, 5'b00011);
		upd(18'sd6, -18'sd989, 5'h1F, 5'b10010);
		upd(18'sd5, -18'sd991, 5'h1F, 5'b01111);
		upd(18'sd6, -18'sd899, 5'h1F, 5'b10000);
		@(posedge mclk);
		net_value <= -18'sd991;
		gross_value <= 18'sd0;
		repeat (4) @(posedge mclk);
		#1;
		`CHK(closed, 5'b10000)
	endtask : t_out

	task automatic t_over();
		wr(ADDR_CTRL, 32'h00000001, 1'b0);
		wr(ADDR_DIRECTION, 32'h00000015, 1'b0);
		wr(ADDR_TARGET, 32'h00000000, 1'b0);
		wr(8'h0C, 32'h00000000, 1'b0);
		wr(8'h10, 32'h000003E8, 1'b0);
		wr(8'h14, 32'h00001388, 1'b0);
		upd(18'sd999, 18'sd0, 5'h1F, 5'b00001);
		upd(18'sd1000, 18'sd0, 5'h1F, 5'b00010);
		upd(18'sd5000, 18'sd0, 5'h1F, 5'b00110);
		rdchk(ADDR_STATUS, 32'h00000006, 1'b0);
	endtask : t_over

	task automatic t_under();
		wr(ADDR_DIRECTION, 32'h0000002A, 1'b0);
		upd(18'sd1000, 18'sd0, 5'h1F, 5'b00110);
		upd(18'sd1001, 18'sd0, 5'h1F, 5'b00101);
		upd(18'sd5000, 18'sd0, 5'h1F, 5'b00100);
		upd(18'sd5001, 18'sd0, 5'h1F, 5'b00000);
	endtask : t_under

	task automatic t_modes();
		wr(ADDR_CTRL, 32'h00000009, 1'b1);
		wr(ADDR_CTRL, 32'h00006401, 1'b1);
		wr(ADDR_CTRL, 32'h00006301, 1'b0);
		wr(ADDR_CTRL, 32'h00000000, 1'b0);
		upd(18'sd1001, 18'sd0, 5'h1F, 5'b00000);
		wr(ADDR_CTRL, 32'h00000002, 1'b0);
		weight_stable <= 1'b0;
		upd(18'sd1001, 18'sd0, 5'h1F, 5'b00000);
		weight_stable <= 1'b1;
		upd(18'sd1001, 18'sd0, 5'h1F, 5'b00101);
	endtask : t_modes

	task automatic t_hyst();
		wr(ADDR_CTRL, 32'h00000301, 1'b0);
		wr(ADDR_DIRECTION, 32'h00000015, 1'b0);
		upd(18'sd0, 18'sd0, 5'b00010, 5'b00000);
		upd(18'sd1001, 18'sd0, 5'b00010, 5'b00000);
		upd(18'sd1010, 18'sd0, 5'b00010, 5'b00010);
		upd(18'sd999, 18'sd0, 5'b00010, 5'b00000);
		wr(ADDR_CTRL, 32'h00000311, 1'b0);
		upd(18'sd1000, 18'sd0, 5'b00010, 5'b00010);
		upd(18'sd998, 18'sd0, 5'b00010, 5'b00010);
		upd(18'sd990, 18'sd0, 5'b00010, 5'b00000);
	endtask : t_hyst

	task automatic t_select();
		wr(ADDR_CTRL, 32'h00000004, 1'b0);
		wr(ADDR_TARGET, 32'h00000018, 1'b0);
		display_is_net <= 1'b1;
		upd(18'sd6000, 18'sd1000, 5'h1F, 5'b00110);
		upd(18'sd4999, 18'sd999, 5'h1F, 5'b00001);
		upd(18'sd6000, 18'sd5, 5'h1F, 5'b00000);
		wr(ADDR_CTRL, 32'h00000006, 1'b0);
		upd(18'sd6000, -18'sd6, 5'h1F, 5'b00101);
		wr(ADDR_CTRL, 32'h00000003, 1'b0);
		upd(18'sd6000, -18'sd6, 5'h1F, 5'b00000);
		wr(ADDR_CTRL, 32'h00000005, 1'b0);
		weight_stable <= 1'b0;
		upd(18'sd6000, -18'sd6, 5'h1F, 5'b00101);
		weight_stable <= 1'b1;
	endtask : t_select

	// ==========================================
	// verdict
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : results

	// ==========================================
	// clock, reset, sequence, watchdog
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	initial begin
		error_cnt = 0;
		num_checks = 0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		disp_update = 1'b0;
		display_is_net = 1'b0;
		weight_stable = 1'b1;
		gross_value = '0;
		net_value = '0;
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		t_reset();
		t_in();
		t_out();
		t_over();
		t_under();
		t_modes();
		t_hyst();
		t_select();
		results();
	end

	initial begin
		#100000;
		error_cnt++;
		results();
	end
endmodule : testbench
